// File: logic/bitbranch_exec.sv
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none

module bitbranch_exec
  import bitbranch_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  output logic BUSY,
  output logic FETCH_FLUSH
);

  // ********************************
  // Declarations
  // ********************************
  logic aw_ready, next_aw_ready, w_ready, next_w_ready;
  logic aw_got, next_aw_got, w_got, next_w_got;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic b_valid, next_b_valid, ar_ready, next_ar_ready;
  logic r_valid, next_r_valid, do_wr;
  logic [1:0] b_resp, next_b_resp, r_resp, next_r_resp;
  logic [31:0] r_data, next_r_data, wv;
  exec_state_t state, next_state;
  op_kind_t opk, next_opk;
  logic [15:0] instr, next_instr;
  logic two_word, next_two_word;
  logic [PC_W-1:0] pc, next_pc, target;
  logic [FLAG_W-1:0] flags, next_flags;
  logic [BSR_W-1:0] bank_select_reg, next_bsr;
  logic [DADDR_W-1:0] maddr, next_maddr, faddr;
  logic [7:0] operand, next_operand, result, next_result;
  logic taken, next_taken, tbit, next_tbit;
  logic hit, next_hit, bad_op, next_bad_op;
  logic busy, next_busy, fetch_flush, next_fetch_flush;
  logic [1:0] last_cycles, next_last_cycles;
  logic [1:0] nop_ph, next_nop_ph, nop_left, next_nop_left;
  logic mem_we, exec_we;
  logic [DADDR_W-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic [7:0] mem [0:DMEM_DEPTH-1];

  // ********************************
  // Helpers
  // ********************************
  // Byte-lane merge so narrow writes leave other lanes alone
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        m[8*i +: 8] = nw[8*i +: 8];
    return m;
  endfunction : merge

  function automatic logic addr_ok(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    return (w == ADDR_CTRL) || (w == ADDR_PC) || (w == ADDR_FLAGS) || (w == ADDR_BSR) ||
           (w == ADDR_STATUS) || (w == ADDR_MADDR) || (w == ADDR_MDATA);
  endfunction : addr_ok

  // Register view used for reads and for merging partial writes
  function automatic logic [31:0] reg_view(input logic [7:0] a);
    logic [31:0] v;
    v = RESET_WORD;
    case ({a[7:2], 2'b00})
      ADDR_CTRL: v = {15'h0000, two_word, instr};
      ADDR_PC: v[PC_W-1:0] = pc;
      ADDR_FLAGS: v[FLAG_W-1:0] = flags;
      ADDR_BSR: v[BSR_W-1:0] = bank_select_reg;
      ADDR_STATUS:
      begin
        v[STAT_BUSY] = busy;
        v[STAT_HIT] = hit;
        v[STAT_BAD] = bad_op;
        v[STAT_CYC +: 2] = last_cycles;
      end
      ADDR_MADDR: v[DADDR_W-1:0] = maddr;
      ADDR_MDATA: v[7:0] = mem[maddr];
      default: v = RESET_WORD;
    endcase
    return v;
  endfunction : reg_view

  function automatic op_kind_t decode_op(input logic [15:0] ins);
    op_kind_t k;
    k = K_NONE;
    if (ins[15:8] == OPC_CARRY_CLR)
      k = K_CARRY_CLR;
    else if (ins[15:8] == OPC_SIGN_CLR)
      k = K_SIGN_CLR;
    else if (ins[15:8] == OPC_OVF_CLR)
      k = K_OVF_CLR;
    else if (ins[15:8] == OPC_NONZERO)
      k = K_NONZERO;
    else if (ins[15:11] == OPC_ALWAYS)
      k = K_ALWAYS;
    else if (ins[15:12] == OPC_SET_BIT)
      k = K_SET_BIT;
    else if (ins[15:12] == OPC_TEST_SKIP)
      k = K_TEST_SKIP;
    return k;
  endfunction : decode_op

  // Branch condition; flags are only read, never written here
  function automatic logic cond_met(input op_kind_t k, input logic [FLAG_W-1:0] fl);
    case (k)
      K_CARRY_CLR: return !fl[FLAG_C];
      K_SIGN_CLR: return !fl[FLAG_N];
      K_OVF_CLR: return !fl[FLAG_OV];
      K_NONZERO: return !fl[FLAG_Z];
      K_ALWAYS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : cond_met

  // ********************************
  // Target and bank address
  // ********************************
  pc_target_calc u_target (
    .pc(pc),
    .ins(instr),
    .long_off(opk == K_ALWAYS),
    .target(target)
  );

  bank_addr_sel u_bank (
    .access(instr[8]),
    .bank(bank_select_reg),
    .f(instr[7:0]),
    .faddr(faddr)
  );

  // ********************************
  // AXI4-Lite slave
  // ********************************
  // One write and one read in flight; address and data taken in either order
  always_comb
  begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_b_valid = b_valid;
    next_b_resp = b_resp;
    next_ar_ready = ar_ready;
    next_r_valid = r_valid;
    next_r_data = r_data;
    next_r_resp = r_resp;
    do_wr = 1'b0;
    if (AWVALID && aw_ready)
    begin
      next_aw_got = 1'b1;
      next_aw_addr = AWADDR;
    end
    if (WVALID && w_ready)
    begin
      next_w_got = 1'b1;
      next_w_data = WDATA;
      next_w_strb = WSTRB;
    end
    if (b_valid && BREADY)
      next_b_valid = 1'b0;
    if (aw_got && w_got && !b_valid)
    begin
      do_wr = 1'b1;
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_b_valid = 1'b1;
      next_b_resp = addr_ok(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    next_aw_ready = !next_aw_got && !next_b_valid;
    next_w_ready = !next_w_got && !next_b_valid;
    if (r_valid && RREADY)
    begin
      next_r_valid = 1'b0;
      next_ar_ready = 1'b1;
    end
    if (ARVALID && ar_ready)
    begin
      next_ar_ready = 1'b0;
      next_r_valid = 1'b1;
      next_r_resp = addr_ok(ARADDR) ? RESP_OKAY : RESP_SLVERR;
      next_r_data = reg_view(ARADDR);
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      aw_ready <= 1'b1;
      w_ready <= 1'b1;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= RESET_WORD;
      w_strb <= 4'h0;
      b_valid <= 1'b0;
      b_resp <= RESP_OKAY;
      ar_ready <= 1'b1;
      r_valid <= 1'b0;
      r_data <= RESET_WORD;
      r_resp <= RESP_OKAY;
    end
    else if (CE)
    begin
      aw_ready <= next_aw_ready;
      w_ready <= next_w_ready;
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      b_valid <= next_b_valid;
      b_resp <= next_b_resp;
      ar_ready <= next_ar_ready;
      r_valid <= next_r_valid;
      r_data <= next_r_data;
      r_resp <= next_r_resp;
    end
  end

  // ********************************
  // Execution sequencer
  // ********************************
  // Software writes land only while idle, so an instruction sees fixed state
  always_comb
  begin
    next_state = state;
    next_opk = opk;
    next_instr = instr;
    next_two_word = two_word;
    next_pc = pc;
    next_flags = flags;
    next_bsr = bank_select_reg;
    next_maddr = maddr;
    next_operand = operand;
    next_result = result;
    next_taken = taken;
    next_tbit = tbit;
    next_hit = hit;
    next_bad_op = bad_op;
    next_last_cycles = last_cycles;
    next_nop_ph = nop_ph;
    next_nop_left = nop_left;
    next_fetch_flush = 1'b0;
    exec_we = 1'b0;
    mem_we = 1'b0;
    mem_wa = maddr;
    mem_wd = w_data[7:0];
    wv = merge(reg_view(aw_addr), w_data, w_strb);
    case (state)
      ST_IDLE:
      begin
        if (do_wr)
          case ({aw_addr[7:2], 2'b00})
            ADDR_CTRL:
            begin
              next_instr = wv[15:0];
              next_two_word = wv[CTRL_TWO_WORD];
              next_state = ST_Q1;
            end
            ADDR_PC: next_pc = wv[PC_W-1:0];
            ADDR_FLAGS: next_flags = wv[FLAG_W-1:0];
            ADDR_BSR: next_bsr = wv[BSR_W-1:0];
            ADDR_MADDR: next_maddr = wv[DADDR_W-1:0];
            ADDR_MDATA: mem_we = w_strb[0];
            default: ;
          endcase
      end
      ST_Q1:
      begin
        next_opk = decode_op(instr);
        next_state = ST_Q2;
      end
      ST_Q2:
      begin
        next_operand = mem[faddr];
        next_state = ST_Q3;
      end
      ST_Q3:
      begin
        // Whole byte is rebuilt so the write-back keeps the other bits
        next_result = operand | (8'h01 << instr[11:9]);
        next_tbit = operand[instr[11:9]];
        next_taken = cond_met(opk, flags);
        next_state = ST_Q4;
      end
      ST_Q4:
      begin
        next_nop_left = 2'h0;
        next_nop_ph = 2'h0;
        next_bad_op = (opk == K_NONE);
        next_hit = 1'b0;
        next_pc = pc + PC_STEP;
        if (opk == K_SET_BIT)
        begin
          exec_we = 1'b1;
          mem_we = 1'b1;
          mem_wa = faddr;
          mem_wd = result;
        end
        else if (opk == K_TEST_SKIP && !tbit)
        begin
          // Skipping a two-word instruction costs one more idle cycle
          next_nop_left = two_word ? 2'h2 : 2'h1;
          next_pc = pc + PC_STEP + PC_STEP + (two_word ? PC_STEP : 21'h000000);
          next_hit = 1'b1;
          next_fetch_flush = 1'b1;
        end
        else if (taken)
        begin
          next_pc = target;
          next_nop_left = 2'h1;
          next_hit = 1'b1;
          next_fetch_flush = 1'b1;
        end
        next_last_cycles = 2'h1 + next_nop_left;
        next_state = (next_nop_left == 2'h0) ? ST_IDLE : ST_NOP;
      end
      ST_NOP:
      begin
        // Each lost instruction cycle is four idle phases while fetch refills
        next_nop_ph = nop_ph + 2'h1;
        if (nop_ph == PHASE_LAST)
        begin
          next_nop_left = nop_left - 2'h1;
          if (nop_left == 2'h1)
            next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    next_busy = (next_state != ST_IDLE);
  end

  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state <= ST_IDLE;
      opk <= K_NONE;
      instr <= 16'h0000;
      two_word <= 1'b0;
      pc <= 21'h000000;
      flags <= 5'h00;
      bank_select_reg <= 4'h0;
      maddr <= 12'h000;
      operand <= 8'h00;
      result <= 8'h00;
      taken <= 1'b0;
      tbit <= 1'b0;
      hit <= 1'b0;
      bad_op <= 1'b0;
      last_cycles <= 2'h0;
      nop_ph <= 2'h0;
      nop_left <= 2'h0;
      busy <= 1'b0;
      fetch_flush <= 1'b0;
    end
    else if (CE)
    begin
      state <= next_state;
      opk <= next_opk;
      instr <= next_instr;
      two_word <= next_two_word;
      pc <= next_pc;
      flags <= next_flags;
      bank_select_reg <= next_bsr;
      maddr <= next_maddr;
      operand <= next_operand;
      result <= next_result;
      taken <= next_taken;
      tbit <= next_tbit;
      hit <= next_hit;
      bad_op <= next_bad_op;
      last_cycles <= next_last_cycles;
      nop_ph <= next_nop_ph;
      nop_left <= next_nop_left;
      busy <= next_busy;
      fetch_flush <= next_fetch_flush;
    end
  end

  // Data memory has no reset; contents are whatever software loads or a bit-set write-back leaves
  always_ff @(posedge REF_CLK)
  begin
    if (CE && mem_we)
      mem[mem_wa] <= mem_wd;
  end

  assign AWREADY = aw_ready;
  assign WREADY = w_ready;
  assign BVALID = b_valid;
  assign BRESP = b_resp;
  assign ARREADY = ar_ready;
  assign RVALID = r_valid;
  assign RDATA = r_data;
  assign RRESP = r_resp;
  assign BUSY = busy;
  assign FETCH_FLUSH = fetch_flush;

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  chk_branch_target: assert property (CE && state == ST_Q4 && taken
    |=> pc == $past(target)) else $error("taken branch target wrong");
  chk_fail_single: assert property (CE && state == ST_Q4 && !taken
    && opk inside {K_CARRY_CLR, K_SIGN_CLR, K_OVF_CLR, K_NONZERO}
    |=> state == ST_IDLE && last_cycles == 2'h1) else $error("failed branch not one cycle");
  chk_taken_two: assert property (CE && state == ST_Q4 && taken
    |=> state == ST_NOP && last_cycles == 2'h2 && FETCH_FLUSH) else $error("taken not two cycles");
  chk_carry_cond: assert property (CE && state == ST_Q3 && opk == K_CARRY_CLR
    |=> taken == !$past(flags[FLAG_C])) else $error("carry condition wrong");
  chk_sign_cond: assert property (CE && state == ST_Q3 && opk == K_SIGN_CLR
    |=> taken == !$past(flags[FLAG_N])) else $error("negative condition wrong");
  chk_ovf_cond: assert property (CE && state == ST_Q3 && opk == K_OVF_CLR
    |=> taken == !$past(flags[FLAG_OV])) else $error("overflow condition wrong");
  chk_zero_cond: assert property (CE && state == ST_Q3 && opk == K_NONZERO
    |=> taken == !$past(flags[FLAG_Z])) else $error("zero condition wrong");
  chk_always_taken: assert property (CE && state == ST_Q3 && opk == K_ALWAYS
    |=> taken ##1 (!$past(CE) || state == ST_NOP)) else $error("branch always not taken");
  chk_bit_set: assert property (CE && state == ST_Q4 && opk == K_SET_BIT
    |=> mem[$past(faddr)][$past(instr[11:9])] && state == ST_IDLE) else $error("bit not set");
  chk_access_bank: assert property (state == ST_Q2 && !instr[8]
    |-> faddr == {(instr[7] ? ACCESS_HI_BANK : 4'h0), instr[7:0]}) else $error("bank wrong");
  chk_skip_flush: assert property (CE && state == ST_Q4 && opk == K_TEST_SKIP && !tbit
    |=> FETCH_FLUSH && pc != $past(pc) + PC_STEP) else $error("skip did not flush");
  chk_skip_cycles: assert property (CE && state == ST_Q4 && opk == K_TEST_SKIP
    |=> last_cycles == ($past(tbit) ? 2'h1 : ($past(two_word) ? 2'h3 : 2'h2)))
    else $error("skip cycle count wrong");
  chk_flags_kept: assert property (state != ST_IDLE
    |=> flags == $past(flags)) else $error("flags changed during execution");
  chk_phase_order: assert property (CE && state == ST_Q1
    |=> state == ST_Q2 ##1 (!$past(CE) || state == ST_Q3)) else $error("phase order broken");
  chk_write_q4: assert property (exec_we |-> state == ST_Q4 && opk == K_SET_BIT
    && mem_wd == (operand | (8'h01 << instr[11:9]))) else $error("write-back not in phase four");

endmodule : bitbranch_exec
`default_nettype wire

// File: pkg/bitbranch_pkg.sv
`default_nettype none
package bitbranch_pkg;

  // ********************************
  // Register map (byte addresses)
  // ********************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PC = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_BSR = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MADDR = 8'h14;
  localparam logic [7:0] ADDR_MDATA = 8'h18;

  // ********************************
  // Field positions and widths
  // ********************************
  localparam int CTRL_TWO_WORD = 16;
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N = 4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_HIT = 1;
  localparam int STAT_BAD = 2;
  localparam int STAT_CYC = 4;
  localparam int PC_W = 21;
  localparam int FLAG_W = 5;
  localparam int BSR_W = 4;
  localparam int DADDR_W = 12;
  localparam int DMEM_DEPTH = 4096;

  // ********************************
  // Opcodes, constants, reset values
  // ********************************
  localparam logic [7:0] OPC_CARRY_CLR = 8'hE3;
  localparam logic [7:0] OPC_SIGN_CLR = 8'hE7;
  localparam logic [7:0] OPC_OVF_CLR = 8'hE5;
  localparam logic [7:0] OPC_NONZERO = 8'hE1;
  localparam logic [4:0] OPC_ALWAYS = 5'h1A;
  localparam logic [3:0] OPC_SET_BIT = 4'h8;
  localparam logic [3:0] OPC_TEST_SKIP = 4'hB;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RESET_WORD = 32'h00000000;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_Q1 = 6'h02,
    ST_Q2 = 6'h04,
    ST_Q3 = 6'h08,
    ST_Q4 = 6'h10,
    ST_NOP = 6'h20
  } exec_state_t;

  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_CARRY_CLR = 3'h1,
    K_SIGN_CLR = 3'h2,
    K_OVF_CLR = 3'h3,
    K_NONZERO = 3'h4,
    K_ALWAYS = 3'h5,
    K_SET_BIT = 3'h6,
    K_TEST_SKIP = 3'h7
  } op_kind_t;

endpackage : bitbranch_pkg
`default_nettype wire

// File: logic/pc_target_calc.sv
`timescale 1ns/10ps
`default_nettype none
module pc_target_calc
  import bitbranch_pkg::*;
(
  input wire logic [PC_W-1:0] pc,
  input wire logic [15:0] ins,
  input wire logic long_off,
  output logic [PC_W-1:0] target
);

  logic [PC_W-1:0] off_ext;

  // Sign-extend the word offset; 11 bits for the unconditional form
  always_comb
  begin
    if (long_off)
      off_ext = {{(PC_W-11){ins[10]}}, ins[10:0]};
    else
      off_ext = {{(PC_W-8){ins[7]}}, ins[7:0]};
  end

  // Offset counts words, so it is doubled; wraps at the top of the space
  assign target = pc + PC_STEP + {off_ext[PC_W-2:0], 1'b0};

endmodule : pc_target_calc
`default_nettype wire

// File: logic/bank_addr_sel.sv
`timescale 1ns/10ps
`default_nettype none
module bank_addr_sel
  import bitbranch_pkg::*;
(
  input wire logic access,
  input wire logic [BSR_W-1:0] bank,
  input wire logic [7:0] f,
  output logic [DADDR_W-1:0] faddr
);

  // Access bank: low half maps to bank 0, high half to the top bank
  always_comb
  begin
    if (access)
      faddr = {bank, f};
    else if (f < ACCESS_SPLIT)
      faddr = {4'h0, f};
    else
      faddr = {ACCESS_HI_BANK, f};
  end

endmodule : bank_addr_sel
`default_nettype wire

// File: test/branch_and_bit_op_execute_test.sv
`timescale 1ns/10ps
`default_nettype none
module branch_and_bit_op_execute_test import bitbranch_pkg::*;;
  logic REF_CLK = 1'h0;
  logic ARST_N = 1'h0;
  logic CE = 1'h1;
  logic [7:0] AWADDR = 8'h00;
  logic [7:0] ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h00000000;
  logic [3:0] WSTRB = 4'hF;
  logic AWVALID = 1'h0;
  logic WVALID = 1'h0;
  logic BREADY = 1'h0;
  logic ARVALID = 1'h0;
  logic RREADY = 1'h0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, BUSY, FETCH_FLUSH;
  logic [1:0] BRESP, RRESP;
  logic [31:0] RDATA;
  int n_fail = 0;
  int num_checks = 0;
  int seed = 35269;
  int busy_n = 0;
  int fl_n = 0;
  int m_pc, m_fl, m_bank;
  logic [7:0] mem [int];

  bitbranch_exec bitbranch_exec_i (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .CE(CE),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
    .RVALID(RVALID), .RREADY(RREADY), .BUSY(BUSY), .FETCH_FLUSH(FETCH_FLUSH));

  // 40 MHz clock
  always #12.5 REF_CLK = ~REF_CLK;

  // Busy and flush counters, cleared before each instruction
  // Only enabled edges count, since a frozen cycle does not advance the core
  always @(posedge REF_CLK)
  begin
    if (CE === 1'h1 && BUSY === 1'h1) busy_n++;
    if (CE === 1'h1 && FETCH_FLUSH === 1'h1) fl_n++;
  end

  // ****************************************
  // Bus tasks and comparison
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Address and data offered together; each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    @(posedge REF_CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'h1;
    WVALID <= 1'h1;
    BREADY <= 1'h1;
    do
    begin
      @(posedge REF_CLK);
      if (AWREADY === 1'h1) AWVALID <= 1'h0;
      if (WREADY === 1'h1) WVALID <= 1'h0;
      t++;
    end while (BVALID !== 1'h1 && t < 50);
    BREADY <= 1'h0;
    r = BRESP;
    if (t >= 50) n_fail++;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    @(posedge REF_CLK);
    ARADDR <= a;
    ARVALID <= 1'h1;
    RREADY <= 1'h1;
    do
    begin
      @(posedge REF_CLK);
      if (ARREADY === 1'h1) ARVALID <= 1'h0;
      t++;
    end while (RVALID !== 1'h1 && t < 50);
    RREADY <= 1'h0;
    d = RDATA;
    r = RRESP;
    if (t >= 50) n_fail++;
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, d, e);
  endtask : rc

  // ****************************************
  // Reference model
  // ****************************************
  function automatic int fadr(input logic [15:0] ins);
    if (ins[8]) return m_bank * 256 + ins[7:0];
    if (ins[7]) return 12'hF00 + ins[7:0];
    return ins[7:0];
  endfunction : fadr

  task automatic setr(input int pc, input int fl, input int bank);
    logic [1:0] r;
    m_pc = pc & 32'h001FFFFE;
    m_fl = fl & 32'h0000001F;
    m_bank = bank & 32'h0000000F;
    wr(ADDR_PC, m_pc, r);
    wr(ADDR_FLAGS, m_fl, r);
    wr(ADDR_BSR, m_bank, r);
  endtask : setr

  task automatic poke(input int fa, input logic [7:0] v);
    logic [1:0] r;
    mem[fa] = v;
    wr(ADDR_MADDR, fa, r);
    wr(ADDR_MDATA, {24'h000000, v}, r);
  endtask : poke

  // Runs one instruction and compares counter, status, flags, timing, flush
  task automatic run(input logic [15:0] ins, input logic tw);
    int n, cyc, hit, fa, npc, t, bad;
    logic [1:0] r;
    logic [7:0] b;
    cyc = 1;
    hit = 0;
    fa = fadr(ins);
    b = 8'h01 << ins[11:9];
    bad = !(ins[15:12] inside {OPC_SET_BIT, OPC_TEST_SKIP} || ins[15:11] == OPC_ALWAYS ||
            ins[15:8] inside {OPC_CARRY_CLR, OPC_SIGN_CLR, OPC_OVF_CLR, OPC_NONZERO});
    if (ins[15:11] == OPC_ALWAYS) hit = 1;
    if (ins[15:8] == OPC_CARRY_CLR) hit = !m_fl[FLAG_C];
    if (ins[15:8] == OPC_SIGN_CLR) hit = !m_fl[FLAG_N];
    if (ins[15:8] == OPC_OVF_CLR) hit = !m_fl[FLAG_OV];
    if (ins[15:8] == OPC_NONZERO) hit = !m_fl[FLAG_Z];
    n = (ins[15:12] == 4'hD) ? $signed(ins[10:0]) : $signed(ins[7:0]);
    npc = hit ? m_pc + 2 + 2 * n : m_pc + 2;
    if (hit) cyc = 2;
    if (ins[15:12] == OPC_SET_BIT) mem[fa] = mem[fa] | b;
    if (ins[15:12] == OPC_TEST_SKIP && (mem[fa] & b) == 0)
    begin
      hit = 1;
      cyc = tw ? 3 : 2;
      npc = m_pc + (tw ? 6 : 4);
    end
    busy_n = 0;
    fl_n = 0;
    wr(ADDR_CTRL, {15'h0000, tw, ins}, r);
    // Bus is quiet while the core runs, so the enable may stall it at random
    t = 0;
    while (BUSY !== 1'h0 && t < 200)
    begin
      CE <= 1'($random(seed));
      @(posedge REF_CLK);
      t++;
    end
    CE <= 1'h1;
    if (t >= 200) n_fail++;
    repeat (2) @(posedge REF_CLK);
    m_pc = npc & 32'h001FFFFF;
    rc(ADDR_PC, m_pc, "pc");
    rc(ADDR_STATUS, cyc * 16 + hit * 2 + bad * 4, "status");
    rc(ADDR_FLAGS, m_fl, "flags");
    chk("busy", busy_n, 4 * cyc);
    chk("flush", fl_n, hit);
    if (ins[15:12] == OPC_SET_BIT)
    begin
      wr(ADDR_MADDR, fa, r);
      rc(ADDR_MDATA, mem[fa], "mem");
    end
  endtask : run

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // Watchdog well beyond the expected run length
  initial
  begin
    #(25 * 30000);
    n_fail++;
    stop_test();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    logic [7:0] opc [4];
    int fb [4];
    logic [7:0] map [6];
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] ins;
    opc = '{OPC_CARRY_CLR, OPC_SIGN_CLR, OPC_OVF_CLR, OPC_NONZERO};
    fb = '{FLAG_C, FLAG_N, FLAG_OV, FLAG_Z};
    map = '{ADDR_CTRL, ADDR_PC, ADDR_FLAGS, ADDR_BSR, ADDR_STATUS, ADDR_MADDR};
    repeat (2) @(posedge REF_CLK);
    ARST_N <= 1'h1;
    // Reset values, unmapped place, read-only status
    foreach (map[i]) rc(map[i], RESET_WORD, "reset");
    rd(8'h1C, d, r);
    chk("rresp", r, RESP_SLVERR);
    chk("rdata", d, 32'h00000000);
    wr(8'h1C, 32'hFFFFFFFF, r);
    chk("bresp", r, RESP_SLVERR);
    wr(ADDR_STATUS, 32'hFFFFFFFF, r);
    rc(ADDR_STATUS, 32'h00000000, "status ro");
    $display("test registers done");
    // Each conditional branch with its flag clear and set, edge offsets too
    foreach (opc[k])
      for (int tk = 0; tk < 3; tk++)
      begin
        setr($random(seed), ($random(seed) & ~(1 << fb[k])) | (int'(tk == 2) << fb[k]), 0);
        run({opc[k], tk[0] ? 8'h80 : 8'h7F}, 1'h0);
        run({opc[k], 8'($random(seed))}, 1'h0);
      end
    $display("test conditional done");
    // Unconditional branch at both offset limits and a random one
    run({OPC_ALWAYS, 11'h400}, 1'h0);
    run({OPC_ALWAYS, 11'h3FF}, 1'h0);
    run({OPC_ALWAYS, 11'($random(seed))}, 1'h0);
    // Opcodes outside this group only step the counter and flag as bad
    run(16'hE000, 1'h0);
    run(16'hD800, 1'h0);
    $display("test always done");
    // Bit set through the access bank low and high halves and a selected bank
    for (int i = 0; i < 6; i++)
    begin
      setr($random(seed), $random(seed), $random(seed));
      ins = {OPC_SET_BIT, 3'($random(seed)), i[1:0] == 2'h2, i[0], 7'($random(seed))};
      poke(fadr(ins), 8'($random(seed)));
      run(ins, 1'h0);
    end
    $display("test set bit done");
    // Test-skip: bit set, bit clear, bit clear over a two-word instruction
    for (int i = 0; i < 6; i++)
    begin
      setr($random(seed), $random(seed), $random(seed));
      ins = {OPC_TEST_SKIP, 3'($random(seed)), i[0], 8'($random(seed))};
      poke(fadr(ins), (i < 2) ? 8'hFF : 8'h00);
      run(ins, i >= 4);
    end
    $display("test skip done");
    stop_test();
  end
endmodule : branch_and_bit_op_execute_test
`default_nettype wire
